//--- verilog/laser_cfg.svh
// Constants for the laser enable and status logic: register offsets,
// field positions, reset values and timing.
// Assumes a 100 MHz system clock and a byte-addressed 32-bit register bus.
`ifndef LASER_CFG_SVH
`define LASER_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_KHZ 100000
`define START_DELAY_MS 5000

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_IRQ_STAT 5'h08
`define REG_IRQ_MASK 5'h0c
`define REG_DELAY_CNT 5'h10

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_INHIBIT 0
`define CTRL_RST 1'h0
`define IRQ_W 5
`define IRQ_FAULT 0
`define IRQ_ILK_OPEN 1
`define IRQ_READY 2
`define IRQ_EMIT 3
`define IRQ_DELAY_DONE 4
`define IRQ_RST 5'h00

// ****************************************
// Synchronised input positions
// ****************************************
`define IN_W 8
`define IN_SHUT_REQ 0
`define IN_ILK 1
`define IN_RRESET 2
`define IN_SW_OPEN 3
`define IN_KEY_ON 4
`define IN_OVERTEMP 5
`define IN_PWM 6
`define IN_KEY_VAR 7

`endif

//--- verilog/laser_pkg.sv
// Types shared by the laser enable and status logic.
// Assumes nothing beyond a SystemVerilog package scope.
package laser_pkg;

  // Gray codes along off -> wait -> run
  typedef enum logic [1:0]
  {
    ST_OFF = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b11
  } emission_lamp_state_type;

endpackage

//--- verilog/input_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes the inputs are quasi-static levels relative to the clock.
`timescale 1ns/1ps

module input_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

//--- verilog/laser_enable_status.sv
// Enable and status logic behind the laser user I/O connector.
// Assumes isolated pin levels arrive asynchronously and software sits on Avalon-MM.
//
// Notes on behaviour
// - No lasing without shutter open request
// - Keyswitch variant waits five seconds after request
// - Keyswitch variant needs request and switch open
// - Request withdrawn, or switch closed on keyswitch variant, inhibits lasing
// - RF driver needs ready and shutter open
// - Active switch closed only while emitting
// - Fault switch closed during over-temperature
// - Ready switch closed while laser enabled
// - Shutter switch closed when request and open
// - Interlock switch closed while interlock open
// - Five independent status switches
// - No lasing without remote interlock
// - Remote reset holds disabled, release arms
// - Keyswitch variant latches interlock loss
// - OEM variant interlock does not latch
`timescale 1ns/1ps
`include "laser_cfg.svh"

module laser_enable_status
  import laser_pkg::*;
#(
  parameter int unsigned START_DELAY_CYC = `START_DELAY_MS * `CLK_FREQ_KHZ
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Isolated connector inputs, active high after the optocouplers
  input wire logic SHUTTER_REQ_I,
  input wire logic INTERLOCK_I,
  input wire logic REMOTE_RESET_I,
  input wire logic PWM_I,
  // Local inputs
  input wire logic SHUTTER_SW_OPEN_I,
  input wire logic KEYSWITCH_ON_I,
  input wire logic OVERTEMP_I,
  input wire logic KEY_VARIANT_I,
  // Status switches, high closes the switch to output common
  output logic EMISSION_LAMP_O,
  output logic THERMAL_LAMP_O,
  output logic READY_SW_O,
  output logic SHUTTER_LAMP_O,
  output logic ILK_OPEN_SW_O,
  // RF driver supply enable
  output logic RF_ENABLE_O,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Interrupt
  output logic IRQ_O
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [`IN_W-1:0] pins;
  logic [`IN_W-1:0] in_s;

  assign pins = {KEY_VARIANT_I, PWM_I, OVERTEMP_I, KEYSWITCH_ON_I, SHUTTER_SW_OPEN_I,
    REMOTE_RESET_I, INTERLOCK_I, SHUTTER_REQ_I};

  input_sync #(
    .W(`IN_W)
  ) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .async_i(pins),
    .sync_o(in_s)
  );

  logic shut_req, ilk_ok, rreset, sw_open, key_on, overtemp, pwm;

  assign shut_req = in_s[`IN_SHUT_REQ];
  assign ilk_ok = in_s[`IN_ILK];
  assign rreset = in_s[`IN_RRESET];
  assign sw_open = in_s[`IN_SW_OPEN];
  assign key_on = in_s[`IN_KEY_ON];
  assign overtemp = in_s[`IN_OVERTEMP];
  assign pwm = in_s[`IN_PWM];

  // ****************************************
  // Variant strap, caught once after reset release
  // ****************************************
  // The strap passes the synchroniser first, so capture waits for the
  // pipeline to fill rather than reading the raw pin.
  logic [1:0] strap_cnt_q;
  logic key_var_q;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      strap_cnt_q <= 2'h0;
      key_var_q <= 1'b0;
    end
    else if (strap_cnt_q != 2'h3)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      key_var_q <= in_s[`IN_KEY_VAR];
    end
  end

  // ****************************************
  // Arming
  // ****************************************
  logic key_on_q;
  logic rreset_q;
  logic start_evt;
  logic armed_q;
  logic ctrl_inhibit_q;
  logic hold_off;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      key_on_q <= 1'b0;
      rreset_q <= 1'b0;
    end
    else
    begin
      key_on_q <= key_on;
      rreset_q <= rreset;
    end
  end

  // Key turned on or remote reset released
  assign start_evt = (key_on & ~key_on_q) | (rreset_q & ~rreset);
  // Conditions that remove the RF supply outright
  assign hold_off = ~ilk_ok | rreset | overtemp | ctrl_inhibit_q;

  // Keyswitch lasers latch any loss and need a fresh start event; OEM
  // lasers follow the interlock directly. A fault also needs a restart
  // on keyswitch lasers, which is how the remote reset clears it.
  // Arming waits for the strap, else a keyswitch laser would arm as OEM.
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      armed_q <= 1'b0;
    else if (strap_cnt_q != 2'h3)
      armed_q <= 1'b0;
    else if (!key_var_q)
      armed_q <= ~hold_off;
    else if (hold_off || !key_on)
      armed_q <= 1'b0;
    else if (start_evt)
      armed_q <= 1'b1;
  end

  // ****************************************
  // Shutter qualification
  // ****************************************
  logic shutter_ok;

  assign shutter_ok = shut_req & (sw_open | ~key_var_q);

  // ****************************************
  // Start delay and lasing state
  // ****************************************
  emission_lamp_state_type state_q;
  logic [31:0] delay_cnt_q;
  logic delay_done;
  logic go;

  assign go = armed_q & shutter_ok;
  assign delay_done = (delay_cnt_q >= START_DELAY_CYC - 32'd1);

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      state_q <= ST_OFF;
    else
      case (state_q)
        ST_OFF:
          if (go)
            state_q <= key_var_q ? ST_WAIT : ST_RUN;
        ST_WAIT:
          if (!go)
            state_q <= ST_OFF;
          else if (delay_done)
            state_q <= ST_RUN;
        ST_RUN:
          if (!go)
            state_q <= ST_OFF;
        default:
          state_q <= ST_OFF;
      endcase
  end

  // Counter only advances while waiting with all conditions met
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      delay_cnt_q <= 32'h0;
    else if (state_q == ST_WAIT && go && !delay_done)
      delay_cnt_q <= delay_cnt_q + 32'h1;
    else if (state_q != ST_WAIT || !go)
      delay_cnt_q <= 32'h0;
  end

  // ****************************************
  // Status switches and RF enable
  // ****************************************
  logic emission_lamp_ok;

  assign emission_lamp_ok = (state_q == ST_RUN) & go;

  // Each switch is its own flop so the five outputs stay independent
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      READY_SW_O <= 1'b0;
      SHUTTER_LAMP_O <= 1'b0;
      THERMAL_LAMP_O <= 1'b0;
      ILK_OPEN_SW_O <= 1'b0;
      EMISSION_LAMP_O <= 1'b0;
      RF_ENABLE_O <= 1'b0;
    end
    else
    begin
      READY_SW_O <= armed_q & ~hold_off;
      SHUTTER_LAMP_O <= shutter_ok;
      THERMAL_LAMP_O <= overtemp;
      ILK_OPEN_SW_O <= ~ilk_ok;
      EMISSION_LAMP_O <= emission_lamp_ok & pwm;
      // Ready and shutter terms are both inside emission_lamp_ok
      RF_ENABLE_O <= emission_lamp_ok & ~hold_off;
    end
  end

  // ****************************************
  // Events and interrupt
  // ****************************************
  logic [`IRQ_W-1:0] evt;
  logic [`IRQ_W-1:0] evt_lvl_q;
  logic [`IRQ_W-1:0] evt_lvl;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic [`IRQ_W-1:0] irq_clr;

  always_comb
  begin
    evt_lvl = '0;
    evt_lvl[`IRQ_FAULT] = overtemp;
    evt_lvl[`IRQ_ILK_OPEN] = ~ilk_ok;
    evt_lvl[`IRQ_READY] = armed_q & ~hold_off;
    evt_lvl[`IRQ_EMIT] = emission_lamp_ok;
    evt_lvl[`IRQ_DELAY_DONE] = (state_q == ST_WAIT) & go & delay_done;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      evt_lvl_q <= '0;
    else
      evt_lvl_q <= evt_lvl;
  end

  // Rising edges only; none while the synchroniser still shows reset levels
  assign evt = (strap_cnt_q == 2'h3) ? (evt_lvl & ~evt_lvl_q) : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      irq_stat_q <= `IRQ_RST;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | evt;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(irq_stat_q & irq_mask_q);
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // Every access costs one wait state; waitrequest idles high, drops for
  // one cycle to complete the access, then rises again.
  logic wr_take, wr_lane0;

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] offs);
    hit = (addr[4:2] == offs[4:2]);
  endfunction

  assign wr_take = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
  assign wr_lane0 = wr_take & AVS_BYTEENABLE_I[0];

  always_comb
  begin
    irq_clr = '0;
    if (wr_lane0 && hit(AVS_ADDRESS_I, `REG_IRQ_STAT))
    begin
      irq_clr = AVS_WRITEDATA_I[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      AVS_WAITREQUEST_O <= 1'b1;
    else
      AVS_WAITREQUEST_O <= ~(AVS_WAITREQUEST_O & (AVS_READ_I | AVS_WRITE_I));
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_inhibit_q <= `CTRL_RST;
      irq_mask_q <= `IRQ_RST;
    end
    else if (wr_lane0 && hit(AVS_ADDRESS_I, `REG_CTRL))
      ctrl_inhibit_q <= AVS_WRITEDATA_I[`CTRL_INHIBIT];
    else if (wr_lane0 && hit(AVS_ADDRESS_I, `REG_IRQ_MASK))
      irq_mask_q <= AVS_WRITEDATA_I[`IRQ_W-1:0];
  end

  // Read data is loaded as waitrequest falls and held until the next read
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      AVS_READDATA_O <= 32'h0;
    else if (AVS_READ_I && AVS_WAITREQUEST_O)
    begin
      if (hit(AVS_ADDRESS_I, `REG_CTRL))
        AVS_READDATA_O <= {31'h0, ctrl_inhibit_q};
      else if (hit(AVS_ADDRESS_I, `REG_STATUS))
        AVS_READDATA_O <= {8'h0, in_s, 4'h0, key_var_q, armed_q, state_q,
          RF_ENABLE_O, 2'h0, ILK_OPEN_SW_O, SHUTTER_LAMP_O, READY_SW_O,
          THERMAL_LAMP_O, EMISSION_LAMP_O};
      else if (hit(AVS_ADDRESS_I, `REG_IRQ_STAT))
        AVS_READDATA_O <= {27'h0, irq_stat_q};
      else if (hit(AVS_ADDRESS_I, `REG_IRQ_MASK))
        AVS_READDATA_O <= {27'h0, irq_mask_q};
      else if (hit(AVS_ADDRESS_I, `REG_DELAY_CNT))
        AVS_READDATA_O <= delay_cnt_q;
      else
        AVS_READDATA_O <= 32'h0;
    end
  end

endmodule

//--- verification/plc_model.sv
// Model of the machine controller that drives the pulse-width command pin.
// Assumes the bench drives the other isolated inputs as plain levels.
`timescale 1ns/1ps

module plc_model #(
  parameter int PER = 640
) (
  // Clock
  input wire logic clk_i,
  // Command from the bench
  input wire logic pwm_on_i,
  // Pin
  output logic pwm_o
);
  int cnt_q = 0;

  // A period of 625 cycles or more keeps the rate at or below 160 kHz
  always_ff @(posedge clk_i)
  begin
    cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
    pwm_o <= pwm_on_i && (cnt_q < PER / 2);
  end
endmodule

//--- verification/laser_enable_status_chk.sv
// Checker of the status switches, RF enable and bus handshake.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps

module laser_enable_status_chk #(
  parameter int unsigned START_DELAY_CYC = 20
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Pins
  input wire logic SHUTTER_REQ_I,
  input wire logic INTERLOCK_I,
  input wire logic REMOTE_RESET_I,
  input wire logic PWM_I,
  input wire logic SHUTTER_SW_OPEN_I,
  input wire logic OVERTEMP_I,
  input wire logic KEY_VARIANT_I,
  // Outputs
  input wire logic EMISSION_LAMP_O,
  input wire logic THERMAL_LAMP_O,
  input wire logic READY_SW_O,
  input wire logic SHUTTER_LAMP_O,
  input wire logic ILK_OPEN_SW_O,
  input wire logic RF_ENABLE_O,
  input wire logic AVS_WAITREQUEST_O
);
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  int unsigned run_q = 0;

  // Counts how long request and open switch have both been held
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I || !(SHUTTER_REQ_I && SHUTTER_SW_OPEN_I))
      run_q <= 0;
    else if (run_q < START_DELAY_CYC + 8)
      run_q <= run_q + 1;
  end

  // Six samples cover the two sync flops plus logic and output flop
  property p_rf_req;
    !SHUTTER_REQ_I [*6] |-> !RF_ENABLE_O;
  endproperty
  a_rf_req: assert property (p_rf_req) else $error("rf on without request");
  property p_rf_pair;
    RF_ENABLE_O |-> READY_SW_O && SHUTTER_LAMP_O;
  endproperty
  a_rf_pair: assert property (p_rf_pair) else $error("rf without ready");
  property p_key_delay;
    KEY_VARIANT_I && $rose(RF_ENABLE_O) |-> run_q >= START_DELAY_CYC;
  endproperty
  a_key_delay: assert property (p_key_delay) else $error("rf before delay");
  property p_sw_closed;
    (KEY_VARIANT_I && !SHUTTER_SW_OPEN_I) [*6] |-> !SHUTTER_LAMP_O && !RF_ENABLE_O;
  endproperty
  a_sw_closed: assert property (p_sw_closed) else $error("switch closed ignored");
  property p_emit_pwm;
    !PWM_I [*6] |-> !EMISSION_LAMP_O;
  endproperty
  a_emit_pwm: assert property (p_emit_pwm) else $error("emission without pwm");
  property p_fault;
    OVERTEMP_I [*6] |-> THERMAL_LAMP_O;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shown");
  property p_ilk_open;
    !INTERLOCK_I [*6] |-> ILK_OPEN_SW_O && !RF_ENABLE_O;
  endproperty
  a_ilk_open: assert property (p_ilk_open) else $error("interlock open ignored");
  property p_rreset;
    REMOTE_RESET_I [*6] |-> !READY_SW_O && !RF_ENABLE_O;
  endproperty
  a_rreset: assert property (p_rreset) else $error("enabled during reset");
  property p_wait_one;
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
endmodule

//--- verification/laser_enable_status_bench.sv
// Self-checking bench of the laser enable and status logic.
// Assumes the design files, controller model and checker are compiled first.
`timescale 1ns/1ps
`include "laser_cfg.svh"

module laser_enable_status_bench;
  localparam int D = 20;
  logic mclk = 0, rst_n = 0, req = 0, ilk = 1, rr = 0, sw = 0, key = 0, ot = 0, kv = 0;
  logic pwm_on = 0, rd = 0, wr = 0, pwm, emit, therm, rdy, shut, ilko, rf, wq, irq;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, q, rdata;
  logic [5:0] e;
  int mismatches = 0, total_checks = 0, c;

  initial forever #5 mclk = ~mclk;

  laser_enable_status #(.START_DELAY_CYC(D)) dut (
    .MCLK_I(mclk), .RST_N_I(rst_n), .SHUTTER_REQ_I(req), .INTERLOCK_I(ilk),
    .REMOTE_RESET_I(rr), .PWM_I(pwm), .SHUTTER_SW_OPEN_I(sw), .KEYSWITCH_ON_I(key),
    .OVERTEMP_I(ot), .KEY_VARIANT_I(kv), .EMISSION_LAMP_O(emit), .THERMAL_LAMP_O(therm),
    .READY_SW_O(rdy), .SHUTTER_LAMP_O(shut), .ILK_OPEN_SW_O(ilko), .RF_ENABLE_O(rf),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hf),
    .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq), .IRQ_O(irq));

  plc_model #(.PER(640)) plc (.clk_i(mclk), .pwm_on_i(pwm_on), .pwm_o(pwm));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, x, g);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wq !== 1'b0 && n < 40);
    q = rdata;
    wr <= 0;
    rd <= 0;
    if (n == 40) mismatches++;
    @(posedge mclk);
  endtask

  task automatic rf_wait();
    c = 0;
    while (rf !== 1'b1 && c < D + 40)
    begin
      tick(1);
      c++;
    end
  endtask

  // Lands a few cycles into a high phase of the command
  task automatic pwm_high();
    int n;
    n = 0;
    while (pwm !== 1'b0 && n < 700)
    begin
      tick(1);
      n++;
    end
    while (pwm !== 1'b1 && n < 1400)
    begin
      tick(1);
      n++;
    end
    tick(6);
  endtask

  // Strap is sampled after release, so it is set while reset is low
  task automatic reset(input logic v);
    rst_n <= 0;
    kv <= v;
    tick(4);
    rst_n <= 1;
    tick(6);
  endtask

  // Reference outputs {emit, therm, rdy, shut, ilko, rf}, command high
  function automatic logic [5:0] oem_ref(input logic r, input logic i, input logic x,
    input logic t);
    logic ok;
    ok = i && !x && !t;
    return {ok && r, t, ok, r, !i, ok && r};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #600000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    void'($urandom(32'h0dad));
    reset(0);
    pwm_on <= 1;
    for (int k = 0; k < 16; k++)
    begin
      req <= $urandom_range(1);
      ilk <= ($urandom_range(3) != 0);
      rr <= ($urandom_range(3) == 0);
      ot <= ($urandom_range(3) == 0);
      tick(8);
      pwm_high();
      e = oem_ref(req, ilk, rr, ot);
      chk("oem pins", e, {emit, therm, rdy, shut, ilko, rf});
    end
    $display("test oem levels done");
    req <= 1;
    ilk <= 1;
    rr <= 0;
    ot <= 0;
    pwm_on <= 0;
    tick(8);
    bus(0, 5'h14, 0);
    chk("unmapped", 0, q);
    bus(0, `REG_STATUS, 0);
    chk("status", 32'h8c, q & 32'hff);
    bus(1, `REG_IRQ_MASK, 0);
    bus(1, `REG_IRQ_STAT, 32'h1f);
    ot <= 1;
    tick(8);
    ot <= 0;
    tick(8);
    chk("irq masked", 0, irq);
    bus(1, `REG_IRQ_MASK, 32'h1);
    bus(0, `REG_IRQ_MASK, 0);
    chk("mask", 32'h1, q);
    chk("irq", 1, irq);
    bus(1, `REG_IRQ_STAT, 32'h1);
    tick(2);
    chk("irq cleared", 0, irq);
    bus(1, `REG_CTRL, 32'h1);
    tick(6);
    chk("inhibit", 0, {rdy, rf});
    bus(1, `REG_CTRL, 0);
    tick(8);
    chk("resume", 3, {rdy, rf});
    $display("test registers done");
    key <= 1;
    sw <= 1;
    reset(1);
    tick(10);
    chk("disarmed", 0, {rdy, rf});
    key <= 0;
    tick(8);
    key <= 1;
    rf_wait();
    chk("delay", 1, c >= D && c <= D + 10);
    pwm_on <= 1;
    pwm_high();
    chk("emission", 1, emit);
    sw <= 0;
    tick(8);
    chk("switch closed", 0, {shut, rf});
    sw <= 1;
    tick(D / 2);
    // Two sync flops and the step into waiting come off the count
    bus(0, `REG_DELAY_CNT, 0);
    chk("delay count", D / 2 - 3, q);
    req <= 0;
    tick(4);
    req <= 1;
    rf_wait();
    chk("restart", 1, c >= D && c <= D + 10);
    ilk <= 0;
    tick(8);
    ilk <= 1;
    tick(D + 20);
    chk("latched", 0, {rdy, rf});
    rr <= 1;
    tick(8);
    chk("reset held", 0, {rdy, rf});
    rr <= 0;
    rf_wait();
    chk("rearm", 1, c >= D && c <= D + 10);
    $display("test keyswitch done");
    finish_test();
  end
endmodule

bind laser_enable_status laser_enable_status_chk #(.START_DELAY_CYC(START_DELAY_CYC)) chk_i (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .SHUTTER_REQ_I(SHUTTER_REQ_I),
  .INTERLOCK_I(INTERLOCK_I), .REMOTE_RESET_I(REMOTE_RESET_I), .PWM_I(PWM_I),
  .SHUTTER_SW_OPEN_I(SHUTTER_SW_OPEN_I), .OVERTEMP_I(OVERTEMP_I),
  .KEY_VARIANT_I(KEY_VARIANT_I), .EMISSION_LAMP_O(EMISSION_LAMP_O),
  .THERMAL_LAMP_O(THERMAL_LAMP_O), .READY_SW_O(READY_SW_O), .SHUTTER_LAMP_O(SHUTTER_LAMP_O),
  .ILK_OPEN_SW_O(ILK_OPEN_SW_O), .RF_ENABLE_O(RF_ENABLE_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O));
